// ---- logic/iodt_entry_decode.sv ----
// Decoder of one translation entry: byte order, page number, mapping code and authority.
`timescale 1ns/1ns
module iodt_entry_decode
(
    iodt_entry_if.decoder ent
);
    import iodt_pkg::*;

    // Memory returns the lowest-addressed byte in the low lane; the entry is big-endian.
    function automatic logic [SYS_W-1:0] swap_bytes(input logic [SYS_W-1:0] d);
        logic [SYS_W-1:0] r;
        r = '0;
        for (int i = 0; i < SYS_W / 8; i++)
        begin
            r[8*i +: 8] = d[SYS_W - 8 - 8*i +: 8];
        end
        return r;
    endfunction

    wire logic [SYS_W-1:0] entry_val;
    wire iodt_perm_e code;
    wire logic mapped;
    wire logic readable;
    wire logic writable;

    assign entry_val = swap_bytes(ent.raw); // [RULE19]
    assign code = iodt_perm_e'(entry_val[CODE_LSB +: CODE_W]); // [RULE9] [RULE14]
    assign mapped = (code != IODT_PERM_FAULT);
    assign readable = (code == IODT_PERM_RO) || (code == IODT_PERM_RW);
    assign writable = (code == IODT_PERM_WO) || (code == IODT_PERM_RW);
    // Reserved bits between the code and the page number are never looked at.
    assign ent.real_page_number = mapped ? entry_val[RPN_LSB +: RPN_W] : '0; // [RULE11] [RULE12] [RULE13]
    assign ent.page_fault = !mapped; // [RULE15] [RULE10]
    assign ent.violation = mapped && (ent.is_write ? !writable : !readable); // [RULE16]

endmodule // iodt_entry_decode

// ---- logic/iodt_entry_if.sv ----
// Interface carrying a fetched translation entry to its decoder and the decoded result back.
`timescale 1ns/1ns
interface iodt_entry_if;
    import iodt_pkg::*;
    logic [SYS_W-1:0] raw;
    logic is_write;
    logic [RPN_W-1:0] real_page_number;
    logic page_fault;
    logic violation;

    modport requester (output raw, output is_write, input real_page_number, input page_fault,
        input violation);
    modport decoder (input raw, input is_write, output real_page_number, output page_fault,
        output violation);
endinterface

// ---- logic/iodt_pkg.sv ----
// Constants, register map, field layout and types of the DMA page translation unit.
// How it works
// [RULE1] Entry k of the table governs bus page k, counting from page zero.
// [RULE2] Each unit holds its own table base; shared overlapping tables are harmless.
// [RULE3] Table size and base are software registers that may be rewritten.
// [RULE4] After reset 64-bit addressing is off and table size and base are zero.
// [RULE5] A table size of zero is legal with 64-bit addressing enabled.
// [RULE6] Translatable space is bounded by table length and peripheral windows.
// [RULE7] Software stops all DMA before changing table size or base.
// [RULE8] Software should place peripheral windows high and small below 4 GB.
// [RULE9] Each entry holds two control bits: mapped, and read/write authority.
// [RULE10] The unmapped code only flags an error; no page is ever fetched on demand.
// [RULE11] For any mapped code, entry bits 0 to 51 give the real page number.
// [RULE12] Enough real page number bits are kept to reach all system memory.
// [RULE13] Entry bits 52 to 61 are reserved and ignored.
// [RULE14] Bits 62-63: 00 fault, 01 read only, 10 write only, 11 read/write.
// [RULE15] Code 00 raises a page fault regardless of every other entry bit.
// [RULE16] Write to a read-only page or read of a write-only page is an error.
// [RULE17] Bus address bits 31 to 12 index the table.
// [RULE18] System address is the real page number followed by bus bits 11 to 0.
// [RULE19] Entries in memory are big-endian.
// [RULE20] Entry sits at base plus eight times index; index beyond length faults.
package iodt_pkg;

    localparam int ADDR_W = 12;
    localparam logic [ADDR_W-1:0] OFF_CTRL = 12'h000;
    localparam logic [ADDR_W-1:0] OFF_TBASE_LO = 12'h004;
    localparam logic [ADDR_W-1:0] OFF_TBASE_HI = 12'h008;
    localparam logic [ADDR_W-1:0] OFF_TSIZE = 12'h00c;
    localparam logic [ADDR_W-1:0] OFF_PMEM_BASE = 12'h010;
    localparam logic [ADDR_W-1:0] OFF_PMEM_LIMIT = 12'h014;
    localparam logic [ADDR_W-1:0] OFF_PIO_BASE = 12'h018;
    localparam logic [ADDR_W-1:0] OFF_PIO_LIMIT = 12'h01c;
    localparam logic [ADDR_W-1:0] OFF_STATUS = 12'h020;
    localparam logic [ADDR_W-1:0] OFF_FAULT_ADDR = 12'h024;
    localparam logic [ADDR_W-1:0] OFF_XLATE_CNT = 12'h028;

    localparam int CTRL_ADDR64 = 0;
    localparam int CTRL_PMEM_EN = 1;
    localparam int CTRL_PIO_EN = 2;
    localparam int CTRL_W = 3;
    localparam logic [CTRL_W-1:0] CTRL_RST = 3'h0;

    localparam int ST_PAGE_FAULT = 0;
    localparam int ST_VIOLATION = 1;
    localparam int ST_INVALID = 2;
    localparam int ST_BUSY = 3;
    localparam int STICKY_W = 3;

    localparam int PAGE_SHIFT = 12;
    localparam int INDEX_W = 20;
    localparam int TSIZE_W = 21;
    localparam logic [TSIZE_W-1:0] TSIZE_RST = 21'h0;
    localparam int ENTRY_SHIFT = 3;
    localparam int ENTRY_ALIGN_MASK = 32'hffff_fff8;
    localparam int RPN_W = 52;
    localparam int RPN_LSB = 12;
    localparam int CODE_LSB = 0;
    localparam int CODE_W = 2;
    localparam int SYS_W = 64;

    typedef enum logic [1:0] {
        IODT_PERM_FAULT = 2'h0,
        IODT_PERM_RO = 2'h1,
        IODT_PERM_WO = 2'h2,
        IODT_PERM_RW = 2'h3
    } iodt_perm_e;

    typedef enum logic [1:0] {
        IODT_ERR_NONE = 2'h0,
        IODT_ERR_PAGE_FAULT = 2'h1,
        IODT_ERR_VIOLATION = 2'h2,
        IODT_ERR_INVALID = 2'h3
    } iodt_err_e;

    typedef enum logic [1:0] {
        IODT_S_IDLE = 2'h0,
        IODT_S_FETCH = 2'h1,
        IODT_S_WAIT = 2'h2,
        IODT_S_RESP = 2'h3
    } iodt_state_e;

endpackage

// ---- logic/iodt_translate.sv ----
// Top of the DMA page translation unit: APB registers, request checks and entry fetch.
`timescale 1ns/1ns
module iodt_translate
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [iodt_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic dma_req_valid,
    output logic dma_req_ready,
    input wire logic [31:0] dma_req_addr,
    input wire logic dma_req_write,
    output logic dma_resp_valid,
    input wire logic dma_resp_ready,
    output logic [iodt_pkg::SYS_W-1:0] dma_resp_addr,
    output iodt_pkg::iodt_err_e dma_resp_err,
    output logic mem_req_valid,
    input wire logic mem_req_ready,
    output logic [iodt_pkg::SYS_W-1:0] mem_req_addr,
    input wire logic mem_rsp_valid,
    input wire logic [iodt_pkg::SYS_W-1:0] mem_rsp_data
);
    import iodt_pkg::*;

    function automatic logic in_window(input logic en, input logic [31:0] a,
        input logic [31:0] lo, input logic [31:0] hi);
        return en && (a >= lo) && (a <= hi);
    endfunction

    // Register file.
    logic [CTRL_W-1:0] ctrl_r;
    logic [31:0] tbase_lo_r;
    logic [31:0] tbase_hi_r;
    logic [TSIZE_W-1:0] tsize_r;
    logic [31:0] pmem_base_r;
    logic [31:0] pmem_limit_r;
    logic [31:0] pio_base_r;
    logic [31:0] pio_limit_r;
    logic [STICKY_W-1:0] sticky_r;
    logic [STICKY_W-1:0] sticky_nxt;
    logic [31:0] fault_addr_r;
    logic [31:0] xlate_cnt_r;
    logic [31:0] prdata_r;
    logic pslverr_r;

    // Translation engine state.
    iodt_state_e state_r;
    iodt_state_e state_nxt;
    logic [31:0] bus_addr_r;
    logic is_write_r;
    logic [SYS_W-1:0] mem_addr_r;
    logic [SYS_W-1:0] resp_addr_r;
    iodt_err_e resp_err_r;

    iodt_entry_if ent ();

    iodt_entry_decode u_decode
    (
        .ent(ent)
    );

    // APB decode.
    wire logic apb_setup;
    wire logic apb_access;
    wire logic apb_wr;
    wire logic addr_mapped;
    wire logic addr_writable;

    assign apb_setup = psel && !penable;
    assign apb_access = psel && penable;
    assign apb_wr = apb_access && pwrite && addr_writable;
    assign addr_mapped = (paddr == OFF_CTRL) || (paddr == OFF_TBASE_LO)
        || (paddr == OFF_TBASE_HI) || (paddr == OFF_TSIZE)
        || (paddr == OFF_PMEM_BASE) || (paddr == OFF_PMEM_LIMIT)
        || (paddr == OFF_PIO_BASE) || (paddr == OFF_PIO_LIMIT)
        || (paddr == OFF_STATUS) || (paddr == OFF_FAULT_ADDR)
        || (paddr == OFF_XLATE_CNT);
    assign addr_writable = addr_mapped && (paddr != OFF_FAULT_ADDR)
        && (paddr != OFF_XLATE_CNT);

    wire logic [31:0] status_word;
    logic [31:0] rd_mux;

    assign status_word = {28'h0, (state_r != IODT_S_IDLE), sticky_r};

    always_comb
    begin
        case (paddr)
            OFF_CTRL: rd_mux = {29'h0, ctrl_r};
            OFF_TBASE_LO: rd_mux = tbase_lo_r;
            OFF_TBASE_HI: rd_mux = tbase_hi_r;
            OFF_TSIZE: rd_mux = {11'h0, tsize_r};
            OFF_PMEM_BASE: rd_mux = pmem_base_r;
            OFF_PMEM_LIMIT: rd_mux = pmem_limit_r;
            OFF_PIO_BASE: rd_mux = pio_base_r;
            OFF_PIO_LIMIT: rd_mux = pio_limit_r;
            OFF_STATUS: rd_mux = status_word;
            OFF_FAULT_ADDR: rd_mux = fault_addr_r;
            OFF_XLATE_CNT: rd_mux = xlate_cnt_r;
            default: rd_mux = 32'h0;
        endcase
    end

    // Read data and error are captured in the setup cycle so they come from flip-flops.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_r <= 32'h0;
            pslverr_r <= 1'b0;
        end
        else if (apb_setup)
        begin
            prdata_r <= pwrite ? 32'h0 : rd_mux;
            pslverr_r <= pwrite ? !addr_writable : !addr_mapped;
        end
    end

    assign prdata = prdata_r;
    assign pslverr = pslverr_r;
    // Every register answers in its access cycle, so no wait state is inserted.
    assign pready = 1'b1;

    // Configuration registers; all start cleared so no table is in use after reset.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_r <= CTRL_RST; // [RULE4]
            tbase_lo_r <= 32'h0; // [RULE4]
            tbase_hi_r <= 32'h0;
            tsize_r <= TSIZE_RST; // [RULE4]
            pmem_base_r <= 32'h0;
            pmem_limit_r <= 32'h0;
            pio_base_r <= 32'h0;
            pio_limit_r <= 32'h0;
        end
        else if (apb_wr)
        begin
            case (paddr)
                OFF_CTRL: ctrl_r <= pwdata[CTRL_W-1:0]; // [RULE5]
                OFF_TBASE_LO: tbase_lo_r <= pwdata & ENTRY_ALIGN_MASK; // [RULE2] [RULE3]
                OFF_TBASE_HI: tbase_hi_r <= pwdata; // [RULE2] [RULE3]
                OFF_TSIZE: tsize_r <= pwdata[TSIZE_W-1:0]; // [RULE3] [RULE5]
                OFF_PMEM_BASE: pmem_base_r <= pwdata;
                OFF_PMEM_LIMIT: pmem_limit_r <= pwdata;
                OFF_PIO_BASE: pio_base_r <= pwdata;
                OFF_PIO_LIMIT: pio_limit_r <= pwdata;
                default: ;
            endcase
        end
    end

    // Request checks on the incoming address.
    wire logic [INDEX_W-1:0] req_index;
    wire logic [TSIZE_W-1:0] req_index_ext;
    wire logic hit_window;
    wire logic index_in_table;
    wire logic [SYS_W-1:0] table_base;
    wire logic [SYS_W-1:0] entry_addr;
    wire logic req_take;
    wire iodt_err_e early_err;

    assign req_index = dma_req_addr[31:PAGE_SHIFT]; // [RULE17] [RULE1]
    assign req_index_ext = {1'b0, req_index};
    assign hit_window = in_window(ctrl_r[CTRL_PMEM_EN], dma_req_addr, pmem_base_r,
        pmem_limit_r) || in_window(ctrl_r[CTRL_PIO_EN], dma_req_addr, pio_base_r,
        pio_limit_r); // [RULE6]
    assign index_in_table = req_index_ext < tsize_r; // [RULE20] [RULE6]
    assign table_base = {tbase_hi_r, tbase_lo_r};
    assign entry_addr = table_base
        + SYS_W'({req_index, ENTRY_SHIFT'(0)}); // [RULE20] [RULE1]
    assign req_take = (state_r == IODT_S_IDLE) && dma_req_valid;

    // Disabled unit and peripheral windows answer invalid; out-of-table pages fault.
    assign early_err = !ctrl_r[CTRL_ADDR64] ? IODT_ERR_INVALID
        : hit_window ? IODT_ERR_INVALID
        : !index_in_table ? IODT_ERR_PAGE_FAULT // [RULE20] [RULE5]
        : IODT_ERR_NONE;

    // Entry decode hookup.
    wire iodt_err_e fetch_err;
    wire logic [SYS_W-1:0] fetch_addr;

    assign ent.raw = mem_rsp_data;
    assign ent.is_write = is_write_r;
    assign fetch_err = ent.page_fault ? IODT_ERR_PAGE_FAULT // [RULE15] [RULE10]
        : ent.violation ? IODT_ERR_VIOLATION // [RULE16]
        : IODT_ERR_NONE;
    assign fetch_addr = fetch_err == IODT_ERR_NONE
        ? {ent.real_page_number, bus_addr_r[PAGE_SHIFT-1:0]} : '0; // [RULE18] [RULE11]

    // Engine sequencing: check, fetch entry, wait for it, then answer.
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            IODT_S_IDLE:
            begin
                if (dma_req_valid)
                begin
                    state_nxt = (early_err == IODT_ERR_NONE) ? IODT_S_FETCH : IODT_S_RESP;
                end
            end
            IODT_S_FETCH:
            begin
                if (mem_req_ready)
                begin
                    state_nxt = IODT_S_WAIT;
                end
            end
            IODT_S_WAIT:
            begin
                if (mem_rsp_valid)
                begin
                    state_nxt = IODT_S_RESP;
                end
            end
            IODT_S_RESP:
            begin
                if (dma_resp_ready)
                begin
                    state_nxt = IODT_S_IDLE;
                end
            end
            default: state_nxt = IODT_S_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_r <= IODT_S_IDLE;
        end
        else
        begin
            state_r <= state_nxt;
        end
    end

    // Request capture and fetch address.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            bus_addr_r <= 32'h0;
            is_write_r <= 1'b0;
            mem_addr_r <= '0;
        end
        else if (req_take)
        begin
            bus_addr_r <= dma_req_addr;
            is_write_r <= dma_req_write;
            mem_addr_r <= entry_addr; // [RULE20]
        end
    end

    // Answer registers.
    wire logic early_done;
    wire logic fetch_done;

    assign early_done = req_take && (early_err != IODT_ERR_NONE);
    assign fetch_done = (state_r == IODT_S_WAIT) && mem_rsp_valid;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            resp_addr_r <= '0;
            resp_err_r <= IODT_ERR_NONE;
        end
        else if (early_done)
        begin
            resp_addr_r <= '0;
            resp_err_r <= early_err;
        end
        else if (fetch_done)
        begin
            resp_addr_r <= fetch_addr; // [RULE18]
            resp_err_r <= fetch_err; // [RULE14]
        end
    end

    // Sticky error flags: a new error in the same cycle as a clear keeps its bit set.
    wire iodt_err_e new_err;
    wire logic err_event;
    wire logic [STICKY_W-1:0] set_bits;
    wire logic [STICKY_W-1:0] clr_bits;

    assign new_err = early_done ? early_err : fetch_done ? fetch_err : IODT_ERR_NONE;
    assign err_event = new_err != IODT_ERR_NONE;
    assign set_bits = {new_err == IODT_ERR_INVALID, new_err == IODT_ERR_VIOLATION,
        new_err == IODT_ERR_PAGE_FAULT};
    assign clr_bits = (apb_wr && (paddr == OFF_STATUS)) ? pwdata[STICKY_W-1:0] : '0;

    always_comb
    begin
        sticky_nxt = (sticky_r & ~clr_bits) | set_bits;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sticky_r <= '0;
            fault_addr_r <= 32'h0;
            xlate_cnt_r <= 32'h0;
        end
        else
        begin
            sticky_r <= sticky_nxt;

            if (err_event)
            begin
                fault_addr_r <= early_done ? dma_req_addr : bus_addr_r;
            end
            if (fetch_done && (fetch_err == IODT_ERR_NONE))
            begin
                xlate_cnt_r <= xlate_cnt_r + 32'h1;
            end
        end
    end

    // Handshake outputs.
    // A new request is refused until the previous answer has been taken.
    assign dma_req_ready = (state_r == IODT_S_IDLE);
    assign dma_resp_valid = (state_r == IODT_S_RESP);
    assign dma_resp_addr = resp_addr_r;
    assign dma_resp_err = resp_err_r;
    assign mem_req_valid = (state_r == IODT_S_FETCH);
    assign mem_req_addr = mem_addr_r;

endmodule // iodt_translate

// ---- tb/iodt_mem_model.sv ----
// Behavioural system memory that serves translation entry fetches.
`timescale 1ns/1ns
module iodt_mem_model
(
    input wire logic pclk,
    input wire logic slow,
    input wire logic mem_req_valid,
    output logic mem_req_ready,
    input wire logic [63:0] mem_req_addr,
    output logic mem_rsp_valid,
    output logic [63:0] mem_rsp_data
);
    logic [63:0] ent [0:127];
    logic [6:0] idx;
    initial
    begin
        mem_req_ready = 1'b0;
        mem_rsp_valid = 1'b0;
        mem_rsp_data = 64'h0;
    end
    // The table lives in the low kilobyte; entries sit eight bytes apart.
    always
    begin
        @(posedge pclk);
        if (mem_req_valid === 1'b1)
        begin
            if (slow)
                repeat (3) @(posedge pclk);
            mem_req_ready <= 1'b1;
            @(posedge pclk);
            idx = mem_req_addr[9:3];
            mem_req_ready <= 1'b0;
            if (slow)
                repeat (2) @(posedge pclk);
            mem_rsp_data <= {<<8{ent[idx]}};
            mem_rsp_valid <= 1'b1;
            @(posedge pclk);
            mem_rsp_valid <= 1'b0;
            mem_rsp_data <= ~mem_rsp_data;
        end
    end
endmodule // iodt_mem_model

// ---- tb/iodt_translate_asserts.sv ----
// Concurrent checks of the translation unit's fetch and response behaviour.
`timescale 1ns/1ns
module iodt_translate_asserts
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic dma_req_valid,
    input wire logic dma_req_ready,
    input wire logic [31:0] dma_req_addr,
    input wire logic dma_req_write,
    input wire logic dma_resp_valid,
    input wire logic dma_resp_ready,
    input wire logic [iodt_pkg::SYS_W-1:0] dma_resp_addr,
    input wire iodt_pkg::iodt_err_e dma_resp_err,
    input wire logic mem_req_valid,
    input wire logic mem_req_ready,
    input wire logic [iodt_pkg::SYS_W-1:0] mem_req_addr,
    input wire logic mem_rsp_valid,
    input wire logic [iodt_pkg::SYS_W-1:0] mem_rsp_data
);
    import iodt_pkg::*;
    logic [11:0] off_r;
    logic wr_r;
    logic wait_r;
    logic got_r;
    logic [SYS_W-1:0] ent_r;
    wire [SYS_W-1:0] ent_swapped = {<<8{mem_rsp_data}};
    wire bad_dir = (ent_r[1:0] == 2'h1 && wr_r) || (ent_r[1:0] == 2'h2 && !wr_r);
    // Remembers the request and the entry that came back for it.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            off_r <= 12'h0;
            wr_r <= 1'b0;
            wait_r <= 1'b0;
            got_r <= 1'b0;
            ent_r <= 64'h0;
        end
        else
        begin
            if (dma_req_valid && dma_req_ready)
            begin
                off_r <= dma_req_addr[11:0];
                wr_r <= dma_req_write;
                got_r <= 1'b0;
            end
            if (mem_req_valid && mem_req_ready)
                wait_r <= 1'b1;
            if (wait_r && mem_rsp_valid)
            begin
                wait_r <= 1'b0;
                got_r <= 1'b1;
                ent_r <= ent_swapped;
            end
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_take;
        dma_req_valid && dma_req_ready;
    endsequence
    sequence s_entry_in;
        wait_r && mem_rsp_valid;
    endsequence
    sequence s_answer;
        $rose(dma_resp_valid) && got_r;
    endsequence
    property p_align;
        mem_req_valid |-> mem_req_addr[2:0] == 3'h0;
    endproperty
    a_align: assert property (p_align) else $error("entry fetch not aligned");
    property p_take_step;
        s_take |=> mem_req_valid || dma_resp_valid;
    endproperty
    a_take_step: assert property (p_take_step) else $error("no step after take");
    property p_one_fetch;
        mem_req_valid && mem_req_ready |=> !mem_req_valid [*2];
    endproperty
    a_one_fetch: assert property (p_one_fetch) else $error("second fetch seen");
    property p_entry_answer;
        s_entry_in |=> dma_resp_valid && !mem_req_valid;
    endproperty
    a_entry_answer: assert property (p_entry_answer) else $error("entry not answered");
    property p_offset;
        $rose(dma_resp_valid) && dma_resp_err == IODT_ERR_NONE |-> dma_resp_addr[11:0] == off_r;
    endproperty
    a_offset: assert property (p_offset) else $error("page offset altered");
    property p_rpn;
        $rose(dma_resp_valid) && dma_resp_err == IODT_ERR_NONE
            |-> got_r && dma_resp_addr[63:12] == ent_r[63:12];
    endproperty
    a_rpn: assert property (p_rpn) else $error("page number wrong");
    property p_fault;
        s_answer ##0 ent_r[1:0] == 2'h0 |-> dma_resp_err == IODT_ERR_PAGE_FAULT;
    endproperty
    a_fault: assert property (p_fault) else $error("unmapped page not faulted");
    property p_violation;
        s_answer ##0 bad_dir |-> dma_resp_err == IODT_ERR_VIOLATION;
    endproperty
    a_violation: assert property (p_violation) else $error("violation missed");
    property p_granted;
        s_answer ##0 (ent_r[1:0] != 2'h0 && !bad_dir) |-> dma_resp_err == IODT_ERR_NONE;
    endproperty
    a_granted: assert property (p_granted) else $error("allowed access refused");
    property p_hold;
        dma_resp_valid && !dma_resp_ready
            |=> dma_resp_valid && $stable(dma_resp_addr) && $stable(dma_resp_err);
    endproperty
    a_hold: assert property (p_hold) else $error("response changed while held");
endmodule // iodt_translate_asserts
bind iodt_translate iodt_translate_asserts iodt_translate_asserts_i (.*);

// ---- tb/iodt_translate_tb.sv ----
// Self-checking testbench of the DMA page translation unit.
`timescale 1ns/1ns
module iodt_translate_tb;
    import iodt_pkg::*;
    localparam int LIM = 200;
    localparam logic [51:0] RB = 52'hf_edcb_a987_6000;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, dma_req_ready, dma_resp_valid, mem_req_valid, mem_req_ready,
        mem_rsp_valid;
    logic dma_req_valid = 1'b0;
    logic [31:0] dma_req_addr = 32'h0;
    logic dma_req_write = 1'b0;
    logic dma_resp_ready = 1'b0;
    logic [SYS_W-1:0] dma_resp_addr;
    iodt_err_e dma_resp_err;
    logic [SYS_W-1:0] mem_req_addr;
    logic [SYS_W-1:0] mem_rsp_data;
    logic slow = 1'b0;
    int n_fail = 0;
    int n_checks = 0;
    logic [31:0] q;
    logic e;
    logic [31:0] ba;
    logic [63:0] ex_adr;
    iodt_err_e ex_err;
    always #2 pclk = ~pclk;
    iodt_translate iodt_translate_i (.*);
    iodt_mem_model iodt_mem_model_i (.*);
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic guard(input logic ok);
        if (ok !== 1'b1)
        begin
            n_fail++;
            $display("BAD handshake expected 1 seen %b", ok);
            conclude();
        end
    endtask
    task automatic chk_reg(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk_dma(input logic [63:0] ea, input iodt_err_e ee);
        n_checks++;
        if (dma_resp_addr !== ea || dma_resp_err !== ee)
        begin
            n_fail++;
            $display("BAD dma response expected %h %0d seen %h %0d", ea, ee, dma_resp_addr,
                dma_resp_err);
        end
    endtask
    task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < LIM);
        guard(pready);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input string what, input logic [ADDR_W-1:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk_reg(what, exp, q);
    endtask
    task automatic dma(input logic [31:0] a, input logic w, input int stall,
        input logic [63:0] ea, input iodt_err_e ee);
        int n;
        dma_req_valid <= 1'b1;
        dma_req_addr <= a;
        dma_req_write <= w;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (dma_req_ready !== 1'b1 && n < LIM);
        guard(dma_req_ready);
        dma_req_valid <= 1'b0;
        n = 0;
        while (dma_resp_valid !== 1'b1 && n < LIM)
        begin
            @(posedge pclk);
            n++;
        end
        guard(dma_resp_valid);
        repeat (stall) @(posedge pclk);
        dma_resp_ready <= 1'b1;
        @(posedge pclk);
        chk_dma(ea, ee);
        dma_resp_ready <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic put(input int i, input logic [51:0] r, input logic [1:0] c);
        iodt_mem_model_i.ent[i] = {r, 10'h2a5, c};
    endtask
    initial
    begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd("control reset", OFF_CTRL, 32'h0);
        rd("base reset", OFF_TBASE_LO, 32'h0);
        rd("size reset", OFF_TSIZE, 32'h0);
        rd("unmapped read", 12'h030, 32'h0);
        chk_reg("unmapped error", 32'h1, {31'h0, e});
        wr(OFF_XLATE_CNT, 32'h5);
        chk_reg("read-only error", 32'h1, {31'h0, e});
        dma(32'h0000_0123, 1'b0, 0, 64'h0, IODT_ERR_INVALID);
        $display("test reset and disabled done");
        wr(OFF_CTRL, 32'h1);
        dma(32'h0000_0123, 1'b1, 0, 64'h0, IODT_ERR_PAGE_FAULT);
        $display("test size zero done");
        wr(OFF_TBASE_LO, 32'h107);
        rd("table base", OFF_TBASE_LO, 32'h100);
        wr(OFF_TSIZE, 32'h8);
        for (int k = 0; k < 8; k++)
            put(32 + k, RB + 52'(k), k[1:0]);
        for (int k = 0; k < 8; k++)
            for (int w = 0; w < 2; w++)
            begin
                ba = {k[19:0], 12'hff8 + k[11:0]};
                ex_err = (k % 4 == 0) ? IODT_ERR_PAGE_FAULT : IODT_ERR_NONE;
                if ((k % 4 == 1 && w == 1) || (k % 4 == 2 && w == 0))
                    ex_err = IODT_ERR_VIOLATION;
                ex_adr = (ex_err == IODT_ERR_NONE) ? {RB + 52'(k), ba[11:0]} : 64'h0;
                dma(ba, w[0], w, ex_adr, ex_err);
            end
        dma(32'h0000_8abc, 1'b0, 0, 64'h0, IODT_ERR_PAGE_FAULT);
        rd("error address", OFF_FAULT_ADDR, 32'h0000_8abc);
        $display("test entry codes done");
        wr(OFF_PMEM_BASE, 32'h5000);
        wr(OFF_PMEM_LIMIT, 32'h5fff);
        wr(OFF_PIO_BASE, 32'h6000);
        wr(OFF_PIO_LIMIT, 32'h6fff);
        wr(OFF_CTRL, 32'h3);
        dma(32'h0000_5000, 1'b0, 0, 64'h0, IODT_ERR_INVALID);
        dma(32'h0000_6fff, 1'b1, 0, {RB + 52'h6, 12'hfff}, IODT_ERR_NONE);
        wr(OFF_CTRL, 32'h5);
        dma(32'h0000_6000, 1'b1, 0, 64'h0, IODT_ERR_INVALID);
        dma(32'h0000_5000, 1'b0, 0, {RB + 52'h5, 12'h000}, IODT_ERR_NONE);
        rd("status", OFF_STATUS, 32'h7);
        wr(OFF_STATUS, 32'h7);
        rd("status cleared", OFF_STATUS, 32'h0);
        rd("translation count", OFF_XLATE_CNT, 32'ha);
        $display("test windows and status done");
        wr(OFF_CTRL, 32'h1);
        wr(OFF_TBASE_LO, 32'h200);
        wr(OFF_TSIZE, 32'h1);
        put(64, 52'h0_0000_0000_0abc, 2'h3);
        slow <= 1'b1;
        dma(32'h0000_0fff, 1'b0, 3, {52'habc, 12'hfff}, IODT_ERR_NONE);
        dma(32'h0000_1000, 1'b1, 0, 64'h0, IODT_ERR_PAGE_FAULT);
        $display("test table move done");
        conclude();
    end
endmodule // iodt_translate_tb
